// *** include/fpm_pkg.sv ***
/*
  Shared constants and types for the panel meter front-panel control:
  timing, display limits, register offsets, field positions, reset values
  and the menu state encoding.
  Assumes a single 100 MHz clock; every time below is converted to cycles.
*/
`default_nettype none

package fpm_pkg;

  // Clock and times, each in its own unit
  localparam int unsigned CLK_HZ = 100_000_000;
  localparam int unsigned TEST_TIME_MS = 3000;
  localparam int unsigned CONV_PER_S = 5;
  localparam int unsigned DEBOUNCE_US = 10000;
  localparam int unsigned BLINK_MS = 250;

  localparam logic [31:0] TEST_CYC = 32'(TEST_TIME_MS * (CLK_HZ / 1000));
  localparam logic [31:0] CONV_CYC = 32'(CLK_HZ / CONV_PER_S);
  localparam logic [31:0] DEBOUNCE_CYC =
    32'(DEBOUNCE_US * (CLK_HZ / 1_000_000));
  localparam logic [31:0] BLINK_CYC = 32'(BLINK_MS * (CLK_HZ / 1000));

  // Display span: 9999 and -1999
  localparam logic signed [15:0] DISP_MAX = 16'sh270f;
  localparam logic signed [15:0] DISP_MIN = 16'shf831;
  localparam logic signed [15:0] ZERO_VAL = 16'sh0000;
  localparam logic signed [15:0] DLY_MAX = 16'sh00ff;
  localparam logic signed [15:0] BRT_MAX = 16'sh0003;

  // Button bit positions
  localparam int B_PROG = 0;
  localparam int B_UP = 1;
  localparam int B_DOWN = 2;

  // Register word offsets
  localparam logic [4:0] A_CTRL = 5'h00;
  localparam logic [4:0] A_STATUS = 5'h01;
  localparam logic [4:0] A_READING = 5'h02;
  localparam logic [4:0] A_PEAK = 5'h03;
  localparam logic [4:0] A_VALLEY = 5'h04;
  localparam logic [4:0] A_SP0 = 5'h05;
  localparam logic [4:0] A_HYS0 = 5'h09;
  localparam logic [4:0] A_MAKE0 = 5'h0d;
  localparam logic [4:0] A_BRK0 = 5'h0f;
  localparam logic [4:0] A_CZERO = 5'h11;
  localparam logic [4:0] A_CSPAN = 5'h12;

  // Control fields
  localparam int CTRL_BRT_LSB = 0;
  localparam int CTRL_DIR_LSB = 2;
  localparam int CTRL_AOUT_BIT = 6;

  // Status fields
  localparam int STAT_ST_LSB = 0;
  localparam int STAT_RLY_LSB = 4;
  localparam int STAT_POVR_BIT = 8;
  localparam int STAT_NOVR_BIT = 9;
  localparam int STAT_IDX_LSB = 10;

  // Reset values
  localparam logic [1:0] BRT_RST = 2'h3;
  localparam logic [3:0] DIR_RST = 4'hf;

  // Menu states, Gray coded along the usual path
  typedef enum logic [3:0] {
    ST_RUN    = 4'h0,
    ST_PEAK   = 4'h1,
    ST_VALLEY = 4'h3,
    ST_VIEW   = 4'h2,
    ST_CZERO  = 4'h6,
    ST_CAOUT  = 4'h7,
    ST_CSPAN  = 4'h5,
    ST_CBRT   = 4'h4,
    ST_SVAL   = 4'hc,
    ST_SDIR   = 4'hd,
    ST_SHYS   = 4'hf,
    ST_SMAKE  = 4'he,
    ST_SBRK   = 4'ha,
    ST_TEST   = 4'hb
  } fpm_state_t;

endpackage

`default_nettype wire

// *** logic/fpm_top.sv ***
/*
  Front-panel control of a four-digit panel meter: button handling, menu
  state machine, display drive, peak and valley, setpoint relays and
  brightness, with a plain register port for software.
  Assumes buttons are active high and synchronous-free raw levels, and a
  signed measurement word that is valid at all times.
*/
// The register offsets and strobed register access are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// - Positive overrange flashes top segments
// - Negative overrange flashes bottom segments
// - Readings outside -1999..9999 are overrange
// - Minus lights only for negative readings
// - Program alone advances to next menu step
// - Program plus up, released, enters calibration
// - Program plus down, released, enters setpoints
// - Up in run views peak/valley; down there clears them
// - Down in run shows setpoints read-only
// - Up press raises the shown value
// - Down press lowers the shown value
// - Two-button command needs both held together
// - Edited parameter alternates name and value
// - Discrete choices step one per press
// - Steps for absent hardware are skipped; setpoint view still shows all four
// - Three-second all-digit test after reset
// - Four brightness levels for digits and lamps
// - Each relay acts above or below setpoint
// - Hysteresis all; make/break delays first two
// - Reading refreshes five times per second
module fpm_top #(
  parameter logic [31:0] TEST_CYC = fpm_pkg::TEST_CYC,
  parameter logic [31:0] CONV_CYC = fpm_pkg::CONV_CYC,
  parameter logic [31:0] DEBOUNCE_CYC = fpm_pkg::DEBOUNCE_CYC,
  parameter logic [31:0] BLINK_CYC = fpm_pkg::BLINK_CYC
) (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic btn_prog,
  input wire logic btn_up,
  input wire logic btn_down,
  input wire logic signed [15:0] meas_value,
  input wire logic aout_present,
  input wire logic [3:0] relay_present,
  input wire logic [4:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  output logic [27:0] seg_out,
  output logic minus_out,
  output logic [3:0] relay_out,
  output logic disp_on
);

  typedef struct packed {
    fpm_pkg::fpm_state_t st;
    logic [1:0] idx;
    logic [2:0] sync1;
    logic [2:0] sync2;
    logic [2:0] db;
    logic [2:0][31:0] deb_cnt;
    logic [2:0] seen;
    logic pu_seen;
    logic pd_seen;
    logic [31:0] test_cnt;
    logic [31:0] conv_cnt;
    logic [31:0] blink_cnt;
    logic blink;
    logic [1:0] pwm;
    logic signed [15:0] reading;
    logic signed [15:0] peak;
    logic signed [15:0] valley;
    logic signed [15:0] cal_zero;
    logic signed [15:0] cal_span;
    logic [3:0][15:0] sp;
    logic [3:0][15:0] hys;
    logic [1:0][7:0] dmake;
    logic [1:0][7:0] dbrk;
    logic [1:0][7:0] dcnt;
    logic [1:0] bright;
    logic [3:0] dir;
    logic aout_mode;
    logic [3:0] relay;
    logic [27:0] seg;
    logic minus;
    logic disp_on;
    logic [15:0] rdata;
  } fpm_regs_t;

  fpm_regs_t s_q;
  fpm_regs_t s_d;
  logic tick;
  logic pos_ovr;
  logic neg_ovr;
  logic ev_prog;
  logic ev_up;
  logic ev_dn;
  logic ev_pu;
  logic ev_pd;
  logic want;
  logic [2:0] nxt;
  logic signed [15:0] val;
  logic [27:0] name;
  logic [15:0] stat;

  function automatic logic [6:0] seg7(input logic [3:0] d);
    case (d)
      4'h0: return 7'h3f;
      4'h1: return 7'h06;
      4'h2: return 7'h5b;
      4'h3: return 7'h4f;
      4'h4: return 7'h66;
      4'h5: return 7'h6d;
      4'h6: return 7'h7d;
      4'h7: return 7'h07;
      4'h8: return 7'h7f;
      4'h9: return 7'h6f;
      default: return 7'h00;
    endcase
  endfunction

  function automatic logic [27:0] num_seg(input logic signed [15:0] v);
    logic [15:0] m;
    m = v[15] ? 16'(-v) : 16'(v);
    return {seg7(4'((m / 16'h03e8) % 16'h000a)),
            seg7(4'((m / 16'h0064) % 16'h000a)),
            seg7(4'((m / 16'h000a) % 16'h000a)),
            seg7(4'(m % 16'h000a))};
  endfunction

  // One press steps a value by one count, held inside lo..hi
  function automatic logic signed [15:0] step_val(
    input logic signed [15:0] v,
    input logic up,
    input logic dn,
    input logic signed [15:0] lo,
    input logic signed [15:0] hi
  );
    if (up && v < hi)
    begin
      return 16'(v + 16'sh0001);
    end
    if (dn && v > lo)
    begin
      return 16'(v - 16'sh0001);
    end
    return v;
  endfunction

  // Lowest fitted setpoint at or after 'from'; top bit marks found
  function automatic logic [2:0] next_sp(
    input logic [2:0] from,
    input logic [3:0] pres
  );
    logic [2:0] r;
    r = 3'h0;
    for (int i = 3; i >= 0; i--)
    begin
      if (3'(i) >= from && pres[i])
      begin
        r = {1'b1, 2'(i)};
      end
    end
    return r;
  endfunction

  // Relay level wanted from reading, setpoint, band and direction
  function automatic logic relay_want(
    input logic cur,
    input logic signed [15:0] rd,
    input logic signed [15:0] sp,
    input logic signed [15:0] hys,
    input logic above
  );
    logic signed [16:0] r;
    logic signed [16:0] off;
    r = 17'(rd);
    if (above)
    begin
      off = 17'(sp) - 17'(hys);
      return cur ? !(r < off) : (r > 17'(sp));
    end
    off = 17'(sp) + 17'(hys);
    return cur ? !(r > off) : (r < 17'(sp));
  endfunction

  always_comb
  begin
    s_d = s_q;
    ev_prog = 1'b0;
    ev_up = 1'b0;
    ev_dn = 1'b0;
    ev_pu = 1'b0;
    ev_pd = 1'b0;
    want = 1'b0;
    nxt = 3'h0;
    val = fpm_pkg::ZERO_VAL;
    name = 28'h0000000;
    stat = 16'h0000;

    // Two-flop synchroniser, then a stable-time filter per button
    s_d.sync1 = {btn_down, btn_up, btn_prog};
    s_d.sync2 = s_q.sync1;
    for (int i = 0; i < 3; i++)
    begin
      if (s_q.sync2[i] != s_q.db[i])
      begin
        s_d.deb_cnt[i] = s_q.deb_cnt[i] + 32'h00000001;
        if (s_q.deb_cnt[i] >= DEBOUNCE_CYC - 32'h00000001)
        begin
          s_d.db[i] = s_q.sync2[i];
          s_d.deb_cnt[i] = 32'h00000000;
        end
      end
      else
      begin
        s_d.deb_cnt[i] = 32'h00000000;
      end
    end

    // A gesture lasts from first press to all released
    if (|s_q.db)
    begin
      s_d.seen = s_q.seen | s_q.db;
      if (s_q.db[fpm_pkg::B_PROG] && s_q.db[fpm_pkg::B_UP])
      begin
        s_d.pu_seen = 1'b1;
      end
      if (s_q.db[fpm_pkg::B_PROG] && s_q.db[fpm_pkg::B_DOWN])
      begin
        s_d.pd_seen = 1'b1;
      end
    end
    else if (|s_q.seen)
    begin
      ev_pu = s_q.pu_seen && !s_q.pd_seen;
      ev_pd = s_q.pd_seen && !s_q.pu_seen;
      ev_prog = s_q.seen == 3'h1;
      ev_up = s_q.seen == 3'h2;
      ev_dn = s_q.seen == 3'h4;
      s_d.seen = 3'h0;
      s_d.pu_seen = 1'b0;
      s_d.pd_seen = 1'b0;
    end

    // Timers: conversion refresh, name/value blink, brightness PWM
    tick = s_q.conv_cnt >= CONV_CYC - 32'h00000001;
    s_d.conv_cnt = tick ? 32'h00000000 : s_q.conv_cnt + 32'h00000001;
    if (s_q.blink_cnt >= BLINK_CYC - 32'h00000001)
    begin
      s_d.blink_cnt = 32'h00000000;
      s_d.blink = !s_q.blink;
    end
    else
    begin
      s_d.blink_cnt = s_q.blink_cnt + 32'h00000001;
    end
    s_d.pwm = 2'(s_q.pwm + 2'h1);
    s_d.disp_on = s_q.pwm <= s_q.bright;

    // New reading, peak/valley and relays on each conversion
    if (tick)
    begin
      s_d.reading = meas_value;
      if (meas_value > s_q.peak)
      begin
        s_d.peak = meas_value;
      end
      if (meas_value < s_q.valley)
      begin
        s_d.valley = meas_value;
      end
      for (int i = 0; i < 4; i++)
      begin
        want = relay_want(s_q.relay[i], s_q.reading, s_q.sp[i],
                          s_q.hys[i], s_q.dir[i]);
        if (i < 2)
        begin
          if (want == s_q.relay[i])
          begin
            s_d.dcnt[i] = 8'h00;
          end
          else if (s_q.dcnt[i] >= (want ? s_q.dmake[i] : s_q.dbrk[i]))
          begin
            s_d.relay[i] = want;
            s_d.dcnt[i] = 8'h00;
          end
          else
          begin
            s_d.dcnt[i] = 8'(s_q.dcnt[i] + 8'h01);
          end
        end
        else
        begin
          s_d.relay[i] = want;
        end
      end
    end
    pos_ovr = s_q.reading > fpm_pkg::DISP_MAX;
    neg_ovr = s_q.reading < fpm_pkg::DISP_MIN;

    // Menu state machine
    case (s_q.st)
      fpm_pkg::ST_TEST:
      begin
        s_d.test_cnt = s_q.test_cnt + 32'h00000001;
        if (s_q.test_cnt >= TEST_CYC - 32'h00000001)
        begin
          s_d.st = fpm_pkg::ST_RUN;
        end
      end
      fpm_pkg::ST_RUN:
      begin
        nxt = next_sp(3'h0, relay_present);
        if (ev_pu)
        begin
          s_d.st = fpm_pkg::ST_CZERO;
        end
        else if (ev_pd && nxt[2])
        begin
          s_d.st = fpm_pkg::ST_SVAL;
          s_d.idx = nxt[1:0];
        end
        else if (ev_up)
        begin
          s_d.st = fpm_pkg::ST_PEAK;
        end
        else if (ev_dn)
        begin
          s_d.st = fpm_pkg::ST_VIEW;
          s_d.idx = 2'h0;
        end
      end
      fpm_pkg::ST_PEAK, fpm_pkg::ST_VALLEY:
      begin
        if (ev_dn)
        begin
          s_d.peak = s_q.reading;
          s_d.valley = s_q.reading;
        end
        if (ev_prog || (ev_up && s_q.st == fpm_pkg::ST_VALLEY))
        begin
          s_d.st = fpm_pkg::ST_RUN;
        end
        else if (ev_up)
        begin
          s_d.st = fpm_pkg::ST_VALLEY;
        end
      end
      fpm_pkg::ST_VIEW:
      begin
        if (ev_prog || (ev_dn && s_q.idx == 2'h3))
        begin
          s_d.st = fpm_pkg::ST_RUN;
        end
        else if (ev_dn)
        begin
          s_d.idx = 2'(s_q.idx + 2'h1);
        end
        else if (ev_up)
        begin
          s_d.idx = 2'(s_q.idx - 2'h1);
        end
      end
      fpm_pkg::ST_CZERO:
      begin
        s_d.cal_zero = step_val(s_q.cal_zero, ev_up, ev_dn,
          fpm_pkg::DISP_MIN, fpm_pkg::DISP_MAX);
        if (ev_prog)
        begin
          s_d.st = aout_present ? fpm_pkg::ST_CAOUT
                                : fpm_pkg::ST_CSPAN;
        end
      end
      fpm_pkg::ST_CAOUT:
      begin
        if (ev_up || ev_dn)
        begin
          s_d.aout_mode = ev_up;
        end
        if (ev_prog)
        begin
          s_d.st = fpm_pkg::ST_CSPAN;
        end
      end
      fpm_pkg::ST_CSPAN:
      begin
        s_d.cal_span = step_val(s_q.cal_span, ev_up, ev_dn,
          fpm_pkg::DISP_MIN, fpm_pkg::DISP_MAX);
        if (ev_prog)
        begin
          s_d.st = fpm_pkg::ST_CBRT;
        end
      end
      fpm_pkg::ST_CBRT:
      begin
        s_d.bright = 2'(step_val({14'h0000, s_q.bright}, ev_up, ev_dn,
          fpm_pkg::ZERO_VAL, fpm_pkg::BRT_MAX));
        if (ev_prog)
        begin
          s_d.st = fpm_pkg::ST_RUN;
        end
      end
      fpm_pkg::ST_SVAL:
      begin
        s_d.sp[s_q.idx] = step_val(s_q.sp[s_q.idx], ev_up, ev_dn,
          fpm_pkg::DISP_MIN, fpm_pkg::DISP_MAX);
        if (ev_prog)
        begin
          s_d.st = fpm_pkg::ST_SDIR;
        end
      end
      fpm_pkg::ST_SDIR:
      begin
        if (ev_up || ev_dn)
        begin
          s_d.dir[s_q.idx] = ev_up;
        end
        if (ev_prog)
        begin
          s_d.st = fpm_pkg::ST_SHYS;
        end
      end
      fpm_pkg::ST_SHYS, fpm_pkg::ST_SBRK:
      begin
        if (s_q.st == fpm_pkg::ST_SHYS)
        begin
          s_d.hys[s_q.idx] = step_val(s_q.hys[s_q.idx], ev_up, ev_dn,
            fpm_pkg::ZERO_VAL, fpm_pkg::DISP_MAX);
        end
        else
        begin
          s_d.dbrk[s_q.idx[0]] = 8'(step_val({8'h00, s_q.dbrk[s_q.idx[0]]},
            ev_up, ev_dn, fpm_pkg::ZERO_VAL, fpm_pkg::DLY_MAX));
        end
        nxt = next_sp(3'(s_q.idx) + 3'h1, relay_present);
        if (ev_prog && s_q.st == fpm_pkg::ST_SHYS && s_q.idx < 2'h2)
        begin
          s_d.st = fpm_pkg::ST_SMAKE;
        end
        else if (ev_prog)
        begin
          s_d.st = nxt[2] ? fpm_pkg::ST_SVAL : fpm_pkg::ST_RUN;
          s_d.idx = nxt[1:0];
        end
      end
      fpm_pkg::ST_SMAKE:
      begin
        s_d.dmake[s_q.idx[0]] = 8'(step_val({8'h00, s_q.dmake[s_q.idx[0]]},
          ev_up, ev_dn, fpm_pkg::ZERO_VAL, fpm_pkg::DLY_MAX));
        if (ev_prog)
        begin
          s_d.st = fpm_pkg::ST_SBRK;
        end
      end
      default:
      begin
        s_d.st = fpm_pkg::ST_RUN;
      end
    endcase

    // Software writes take precedence over a button edit in the same cycle
    if (reg_wr)
    begin
      if (reg_addr == fpm_pkg::A_CTRL)
      begin
        s_d.bright = reg_wdata[fpm_pkg::CTRL_BRT_LSB +: 2];
        s_d.dir = reg_wdata[fpm_pkg::CTRL_DIR_LSB +: 4];
        s_d.aout_mode = reg_wdata[fpm_pkg::CTRL_AOUT_BIT];
      end
      else if (reg_addr >= fpm_pkg::A_SP0 && reg_addr < fpm_pkg::A_HYS0)
      begin
        s_d.sp[2'(reg_addr - fpm_pkg::A_SP0)] = reg_wdata;
      end
      else if (reg_addr >= fpm_pkg::A_HYS0 && reg_addr < fpm_pkg::A_MAKE0)
      begin
        s_d.hys[2'(reg_addr - fpm_pkg::A_HYS0)] = reg_wdata;
      end
      else if (reg_addr >= fpm_pkg::A_MAKE0 && reg_addr < fpm_pkg::A_BRK0)
      begin
        s_d.dmake[1'(reg_addr - fpm_pkg::A_MAKE0)] = reg_wdata[7:0];
      end
      else if (reg_addr >= fpm_pkg::A_BRK0 && reg_addr < fpm_pkg::A_CZERO)
      begin
        s_d.dbrk[1'(reg_addr - fpm_pkg::A_BRK0)] = reg_wdata[7:0];
      end
      else if (reg_addr == fpm_pkg::A_CZERO)
      begin
        s_d.cal_zero = reg_wdata;
      end
      else if (reg_addr == fpm_pkg::A_CSPAN)
      begin
        s_d.cal_span = reg_wdata;
      end
    end

    // Read data stands only in the cycle after the read strobe
    stat[fpm_pkg::STAT_ST_LSB +: 4] = s_q.st;
    stat[fpm_pkg::STAT_RLY_LSB +: 4] = s_q.relay;
    stat[fpm_pkg::STAT_POVR_BIT] = pos_ovr;
    stat[fpm_pkg::STAT_NOVR_BIT] = neg_ovr;
    stat[fpm_pkg::STAT_IDX_LSB +: 2] = s_q.idx;
    s_d.rdata = 16'h0000;
    if (reg_rd)
    begin
      if (reg_addr == fpm_pkg::A_CTRL)
      begin
        s_d.rdata = {9'h000, s_q.aout_mode, s_q.dir, s_q.bright};
      end
      else if (reg_addr == fpm_pkg::A_STATUS)
      begin
        s_d.rdata = stat;
      end
      else if (reg_addr == fpm_pkg::A_READING)
      begin
        s_d.rdata = s_q.reading;
      end
      else if (reg_addr == fpm_pkg::A_PEAK)
      begin
        s_d.rdata = s_q.peak;
      end
      else if (reg_addr == fpm_pkg::A_VALLEY)
      begin
        s_d.rdata = s_q.valley;
      end
      else if (reg_addr >= fpm_pkg::A_SP0 && reg_addr < fpm_pkg::A_HYS0)
      begin
        s_d.rdata = s_q.sp[2'(reg_addr - fpm_pkg::A_SP0)];
      end
      else if (reg_addr >= fpm_pkg::A_HYS0 && reg_addr < fpm_pkg::A_MAKE0)
      begin
        s_d.rdata = s_q.hys[2'(reg_addr - fpm_pkg::A_HYS0)];
      end
      else if (reg_addr >= fpm_pkg::A_MAKE0 && reg_addr < fpm_pkg::A_BRK0)
      begin
        s_d.rdata = {8'h00, s_q.dmake[1'(reg_addr - fpm_pkg::A_MAKE0)]};
      end
      else if (reg_addr >= fpm_pkg::A_BRK0 && reg_addr < fpm_pkg::A_CZERO)
      begin
        s_d.rdata = {8'h00, s_q.dbrk[1'(reg_addr - fpm_pkg::A_BRK0)]};
      end
      else if (reg_addr == fpm_pkg::A_CZERO)
      begin
        s_d.rdata = s_q.cal_zero;
      end
      else if (reg_addr == fpm_pkg::A_CSPAN)
      begin
        s_d.rdata = s_q.cal_span;
      end
    end

    // Display: code name, value and its sign per state
    case (s_q.st)
      fpm_pkg::ST_PEAK:
      begin
        name = {7'h73, 7'h79, 7'h77, 7'h00};
        val = s_q.peak;
      end
      fpm_pkg::ST_VALLEY:
      begin
        name = {7'h1c, 7'h77, 7'h38, 7'h00};
        val = s_q.valley;
      end
      fpm_pkg::ST_VIEW, fpm_pkg::ST_SVAL:
      begin
        name = {7'h6d, 7'h73, 7'h00, seg7(4'(s_q.idx) + 4'h1)};
        val = s_q.sp[s_q.idx];
      end
      fpm_pkg::ST_CZERO:
      begin
        name = {7'h5b, 7'h79, 7'h50, 7'h5c};
        val = s_q.cal_zero;
      end
      fpm_pkg::ST_CAOUT:
      begin
        name = {7'h5c, 7'h1c, 7'h78, 7'h00};
        val = {15'h0000, s_q.aout_mode};
      end
      fpm_pkg::ST_CSPAN:
      begin
        name = {7'h6d, 7'h73, 7'h77, 7'h54};
        val = s_q.cal_span;
      end
      fpm_pkg::ST_CBRT:
      begin
        name = {7'h7c, 7'h50, 7'h00, 7'h00};
        val = {14'h0000, s_q.bright} + 16'sh0001;
      end
      fpm_pkg::ST_SDIR:
      begin
        name = {7'h5e, 7'h06, 7'h50, seg7(4'(s_q.idx) + 4'h1)};
      end
      fpm_pkg::ST_SHYS:
      begin
        name = {7'h76, 7'h6e, 7'h6d, seg7(4'(s_q.idx) + 4'h1)};
        val = s_q.hys[s_q.idx];
      end
      fpm_pkg::ST_SMAKE:
      begin
        name = {7'h5e, 7'h5c, 7'h54, seg7(4'(s_q.idx) + 4'h1)};
        val = {8'h00, s_q.dmake[s_q.idx[0]]};
      end
      fpm_pkg::ST_SBRK:
      begin
        name = {7'h5e, 7'h5c, 7'h71, seg7(4'(s_q.idx) + 4'h1)};
        val = {8'h00, s_q.dbrk[s_q.idx[0]]};
      end
      default:
      begin
        val = s_q.reading;
      end
    endcase

    if (s_q.st == fpm_pkg::ST_TEST)
    begin
      s_d.seg = {4{7'h7f}};
      s_d.minus = 1'b1;
    end
    else if (s_q.st == fpm_pkg::ST_RUN)
    begin
      if (pos_ovr)
      begin
        s_d.seg = s_q.blink ? {4{7'h01}} : 28'h0000000;
      end
      else if (neg_ovr)
      begin
        s_d.seg = s_q.blink ? {4{7'h08}} : 28'h0000000;
      end
      else
      begin
        s_d.seg = num_seg(s_q.reading);
      end
      s_d.minus = s_q.reading[15] && !neg_ovr;
    end
    else if (!s_q.blink)
    begin
      s_d.seg = name;
      s_d.minus = 1'b0;
    end
    else if (s_q.st == fpm_pkg::ST_SDIR)
    begin
      s_d.seg = s_q.dir[s_q.idx] ? {7'h76, 7'h06, 14'h0000}
                                 : {7'h38, 7'h3f, 14'h0000};
      s_d.minus = 1'b0;
    end
    else
    begin
      s_d.seg = num_seg(val);
      s_d.minus = val[15];
    end
  end

  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      s_q <= '0;
      s_q.st <= fpm_pkg::ST_TEST;
      s_q.bright <= fpm_pkg::BRT_RST;
      s_q.dir <= fpm_pkg::DIR_RST;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign reg_rdata = s_q.rdata;
  assign seg_out = s_q.seg;
  assign minus_out = s_q.minus;
  assign relay_out = s_q.relay;
  assign disp_on = s_q.disp_on;

endmodule

`default_nettype wire

// *** testbench/fpm_operator.sv ***
/* Operator model pressing the three front-panel buttons.
   Assumes a released button reads low. */
`timescale 1ns/1ps
`default_nettype none
module fpm_operator (
  input wire logic ref_clk,
  output var logic btn_prog,
  output var logic btn_up,
  output var logic btn_down
);
  initial {btn_down, btn_up, btn_prog} = 3'h0;
  // A gesture presses its buttons together, releases them together n edges later, then idles 12 edges
  task automatic press(input logic [2:0] m, input int n);
    {btn_down, btn_up, btn_prog} <= m;
    repeat (n) @(posedge ref_clk);
    {btn_down, btn_up, btn_prog} <= 3'h0;
    repeat (12) @(posedge ref_clk);
  endtask
endmodule
`default_nettype wire

// *** testbench/fpm_monitor.sv ***
/* Port checker for fpm_top.
   Assumes it is bound to fpm_top and sees only its ports. */
`timescale 1ns/1ps
`default_nettype none
module fpm_monitor #(
  parameter logic [31:0] TEST_CYC = fpm_pkg::TEST_CYC
) (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic [4:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [15:0] reg_rdata,
  input wire logic [27:0] seg_out,
  input wire logic minus_out,
  input wire logic [3:0] relay_out,
  input wire logic disp_on
);
  logic [31:0] up_q;
  logic in_test;
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!nrst);
  // Safely inside the power-up test window
  assign in_test = up_q > 32'h1 && up_q + 32'h3 < TEST_CYC;
  always_ff @(posedge ref_clk or negedge nrst)
    if (!nrst)
      up_q <= 32'h0;
    else
      up_q <= up_q + 32'h1;
  test_segs_a: assert property (
    in_test |-> seg_out == 28'hfffffff) else $error("test digits dark");
  test_sign_a: assert property (
    in_test |-> minus_out) else $error("test sign dark");
  test_lit_a: assert property (
    in_test |-> disp_on) else $error("test display dimmed");
  test_state_a: assert property (
    in_test && reg_rd && reg_addr == fpm_pkg::A_STATUS
    |=> reg_rdata[3:0] == 4'hb) else $error("not in test state");
  relay_hold_a: assert property (
    $changed(relay_out) |=> $stable(relay_out) [*8])
    else $error("relay changed between conversions");
  dim_gap_a: assert property (
    $fell(disp_on) |-> ##[1:3] disp_on) else $error("display dark too long");
  bright_full_a: assert property (
    reg_wr && reg_addr == fpm_pkg::A_CTRL && reg_wdata[1:0] == 2'h3
    ##1 !reg_wr [*4] |-> disp_on [*4]) else $error("full bright not steady");
  hys_back_a: assert property (
    reg_wr && reg_addr == fpm_pkg::A_HYS0 && reg_wdata < 16'h2710
    ##1 reg_rd && reg_addr == fpm_pkg::A_HYS0
    |=> reg_rdata == $past(reg_wdata, 2)) else $error("hysteresis lost");
endmodule
bind fpm_top fpm_monitor #(.TEST_CYC(TEST_CYC)) mon_u (.*);
`default_nettype wire

// *** testbench/fpm_top_tb_top.sv ***
/* Self-checking bench for fpm_top with shortened counts.
   Assumes fpm_operator drives the buttons. */
`timescale 1ns/1ps
`default_nettype none
module fpm_top_tb_top;
  logic ref_clk = 1'b0;
  logic nrst = 1'b0;
  wire logic btn_prog, btn_up, btn_down;
  logic signed [15:0] meas_value = 16'sh0064;
  logic aout_present = 1'b1;
  logic [3:0] relay_present = 4'h1;
  logic [4:0] reg_addr = 5'h00;
  logic [15:0] reg_wdata = 16'h0000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [15:0] reg_rdata, d;
  logic [27:0] seg_out;
  logic minus_out, disp_on;
  logic [3:0] relay_out;
  int bad_count = 0;
  int total_checks = 0;
  int n;
  // Buttons in the high nibble, menu state expected in the low one
  logic [7:0] rows [22] = '{8'h21, 8'h23, 8'h20, 8'h42, 8'h10, 8'h36,
    8'h17, 8'h27, 8'h15, 8'h14, 8'h44, 8'h10, 8'h5c, 8'h2c, 8'h2c, 8'h4c,
    8'h1d, 8'h4d, 8'h1f, 8'h1e, 8'h1a, 8'h10};
  logic [15:0] mv [4] = '{16'h2710, 16'h270f, 16'hf830, 16'hf831};
  logic [1:0] ov [4] = '{2'h1, 2'h0, 2'h2, 2'h0};
  logic [27:0] sm [4] = '{28'h0204081, 28'hdfbf7ef, 28'h1020408,
    28'h0dbf7ef};
  fpm_top #(.TEST_CYC(32'h32), .CONV_CYC(32'h14), .DEBOUNCE_CYC(32'h4),
    .BLINK_CYC(32'h8)) dut_u (.*);
  fpm_operator op_u (.*);
  always #5 ref_clk = ~ref_clk;
  task automatic wt(input int c);
    repeat (c) @(posedge ref_clk);
  endtask
  task automatic wr(input logic [4:0] a, input logic [15:0] v);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    wt(1);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [4:0] a, output logic [15:0] v);
    reg_addr <= a;
    reg_rd <= 1'b1;
    wt(1);
    reg_rd <= 1'b0;
    wt(1);
    v = reg_rdata;
  endtask
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    total_checks++;
    if (g !== e)
    begin
      bad_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic summarize();
    $display("checks=%0d bad=%0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  initial
  begin
    repeat (16) @(posedge ref_clk);
    nrst <= 1'b1;
    wt(4);
    rd(fpm_pkg::A_STATUS, d);
    chk(d & 16'h000f, 16'h000b);
    rd(fpm_pkg::A_CTRL, d);
    chk(d, 16'h003f);
    rd(5'h1f, d);
    chk(d, 16'h0000);
    wt(60);
    chk({15'h0, seg_out == 28'hfffffff}, 16'h0000);
    chk({15'h0, minus_out}, 16'h0000);
    $display("reset test done");
    foreach (rows[i])
    begin
      op_u.press(rows[i][6:4], 8);
      rd(fpm_pkg::A_STATUS, d);
      chk(d & 16'h000f, {12'h000, rows[i][3:0]});
    end
    rd(fpm_pkg::A_SP0, d);
    chk(d, 16'h0001);
    rd(fpm_pkg::A_CTRL, d);
    chk(d, 16'h007a);
    op_u.press(3'h2, 2);
    rd(fpm_pkg::A_STATUS, d);
    chk(d & 16'h000f, 16'h0000);
    $display("menu test done");
    wr(fpm_pkg::A_CTRL, 16'h0078);
    wt(3);
    n = 0;
    repeat (8)
    begin
      wt(1);
      n += (disp_on === 1'b1);
    end
    chk(16'(n), 16'h0002);
    wr(fpm_pkg::A_CTRL, 16'h007b);
    aout_present <= 1'b0;
    op_u.press(3'h3, 8);
    d = seg_out[15:0];
    wt(8);
    chk({15'h0, seg_out[15:0] != d}, 16'h0001);
    op_u.press(3'h1, 8);
    rd(fpm_pkg::A_STATUS, d);
    chk(d & 16'h000f, 16'h0005);
    op_u.press(3'h1, 8);
    op_u.press(3'h1, 8);
    foreach (mv[i])
    begin
      meas_value <= mv[i];
      wt(45);
      rd(fpm_pkg::A_STATUS, d);
      chk(d & 16'h0300, {6'h00, ov[i], 8'h00});
      chk({15'h0, |(seg_out & ~sm[i])}, 16'h0000);
      chk({15'h0, minus_out}, {15'h0, i == 3});
    end
    $display("display test done");
    wr(fpm_pkg::A_SP0, 16'h0064);
    wt(45);
    chk({15'h0, relay_out[0]}, 16'h0001);
    wr(fpm_pkg::A_CTRL, 16'h007f);
    wt(1);
    wr(fpm_pkg::A_HYS0, 16'h0032);
    rd(fpm_pkg::A_HYS0, d);
    chk(d, 16'h0032);
    wt(45);
    chk({15'h0, relay_out[0]}, 16'h0000);
    meas_value <= 16'sh00c8;
    wt(45);
    chk({15'h0, relay_out[0]}, 16'h0001);
    meas_value <= 16'sh0050;
    wt(45);
    chk({15'h0, relay_out[0]}, 16'h0001);
    $display("relay test done");
    summarize();
  end
  // Tests need about 1100 cycles
  initial
  begin
    repeat (20000) @(posedge ref_clk);
    bad_count++;
    summarize();
  end
endmodule
`default_nettype wire
